// File: design/srsr_pkg.sv
// Purpose: shared constants and types of the system reset and stop recovery controller
// Assumes: one clock domain, CORE_CLK at 250 MHz
// Notes: delays are counted in internal oscillator ticks made by a divider
package srsr_pkg;

    localparam int CORE_CLK_MHZ = 250;
    localparam int CORE_PERIOD_NS = 4;

    // qualification of the external reset input, in core clocks of agreed low level
    localparam int EXT_QUAL_CYC = 3;
    localparam int EXT_CNT_W = 3;

    // delay counter width and oscillator divider width
    localparam int DLY_W = 16;
    localparam int DIV_W = 8;

    // stop mode recovery counts in internal oscillator cycles
    localparam logic [DLY_W-1:0] SMR_IPO_CYC = 16'h0042;
    localparam logic [DLY_W-1:0] SMR_XTAL_CYC = 16'h1388;

    // state codes, one-hot
    typedef enum logic [4:0] {
        ST_RUN = 5'b00001,
        ST_RESET = 5'b00010,
        ST_WAIT_PIN = 5'b00100,
        ST_STOP = 5'b01000,
        ST_SMR = 5'b10000
    } srsr_state_t;

    // reset cause codes
    typedef enum logic [2:0] {
        CAUSE_POR = 3'h0,
        CAUSE_BROWNOUT = 3'h1,
        CAUSE_WDT = 3'h2,
        CAUSE_DBG = 3'h3,
        CAUSE_EXT = 3'h4
    } srsr_cause_t;

    // reset cause flags; por and brownout sit in the reset status register,
    // external, watchdog and stop in the watchdog control register
    typedef struct packed {
        logic por;
        logic brownout;
        logic wdt;
        logic external_reset_flag;
        logic stop;
    } srsr_flags_t;

    localparam srsr_flags_t FLAGS_RST = '{por: 1'b1, brownout: 1'b0, wdt: 1'b0,
                                          external_reset_flag: 1'b0, stop: 1'b0};

    // reset request sources from the rest of the chip
    typedef struct packed {
        logic por;
        logic brownout;
        logic wdt_timeout;
    } srsr_req_t;

    // stop mode recovery side effects toward the oscillator and watchdog blocks
    typedef struct packed {
        logic osc_defaults;
        logic wdt_ctl_update;
    } srsr_smr_fx_t;

endpackage : srsr_pkg

// File: design/srsr_pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter for a pin input
// Assumes: pin idles high
// Notes: the level changes only when the second and third stages agree
`timescale 1ns/1ps
module srsr_pin_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin_i,
    output logic level_o
);
    import srsr_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } srsr_sync_t;

    srsr_sync_t st_r;
    srsr_sync_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        if (st_r.s2 == st_r.s3) begin
            st_nxt.lvl = st_r.s3;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= 4'hf;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign level_o = st_r.lvl;

endmodule : srsr_pin_sync

// File: design/srsr_delay.sv
// Purpose: loadable down counter that counts enable ticks
// Assumes: load has priority over tick
// Notes: done is high while the count stands at zero and no load is pending
`timescale 1ns/1ps
module srsr_delay #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic tick,
    output logic done
);
    import srsr_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
    } srsr_dly_t;

    srsr_dly_t st_r;
    srsr_dly_t st_nxt;

    always_comb begin
        st_nxt = st_r;
        if (load) begin
            st_nxt.cnt = load_val;
        end else if (tick && (st_r.cnt != '0)) begin
            st_nxt.cnt = st_r.cnt - {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign done = (st_r.cnt == '0) && !load;

endmodule : srsr_delay

// File: design/srsr_top.sv
// Purpose: system reset controller with stop mode recovery sequencing
// Assumes: request inputs other than the reset pin come from CORE_CLK logic
// Notes: the debugger block takes RESET_N only and is never reset from here
// Operation
// - accept pin, power-on, watchdog, stop exit, brownout
// - four-cycle low pin pulse resets outside port mode
// - held-low pin keeps logic in reset
// - leave reset on edge after pin release
// - pin reset sets external reset flag
// - pin is open-drain reset indicator
// - internal reset drives pin low for delay
// - debugger request starts power-on type reset
// - debugger request bit self-clears during reset
// - debugger reset sets power-on flag
// - stop instruction enters stop, exit recovers
// - recovery holds CPU 66 or 5000 cycles
// - recovery count includes oscillator start-up
// - recovery touches only watchdog and oscillator control
// - recovery enables and selects internal oscillator
// - shared port pin is bidirectional in port mode
// - during reset pin returns to reset function
`timescale 1ns/1ps
module srsr_top #(
    parameter int IPO_DIV = 45,
    parameter logic [15:0] POR_DLY_IPO = 16'h03e8,
    parameter logic [15:0] BO_DLY_IPO = 16'h03e8,
    parameter logic [15:0] WDT_DLY_IPO = 16'h0040,
    parameter logic [15:0] EXT_DLY_IPO = 16'h0040,
    parameter logic [15:0] SMR_XTAL_IPO = srsr_pkg::SMR_XTAL_CYC
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic RST_PIN_I,
    output logic RST_PIN_O,
    output logic RST_PIN_OE_N,
    input wire srsr_pkg::srsr_req_t RST_REQ,
    input wire logic DBG_RST_SET,
    input wire logic STOP_EXEC,
    input wire logic STOP_WAKE,
    input wire logic XTAL_EN,
    input wire logic PORT_MODE,
    input wire logic PORT_DRIVE_LOW,
    input wire logic FLAG_CLR,
    output logic PORT_PIN_LEVEL,
    output logic SYS_RST_N,
    output logic CPU_RST_N,
    output logic STOP_MODE,
    output logic DBG_RST_BIT,
    output srsr_pkg::srsr_flags_t RST_FLAGS,
    output srsr_pkg::srsr_smr_fx_t SMR_FX
);
    import srsr_pkg::*;

    typedef struct packed {
        srsr_state_t state;
        srsr_flags_t flags;
        logic dbg_bit;
        logic [EXT_CNT_W-1:0] ext_cnt;
        logic [DIV_W-1:0] div_cnt;
        logic ipo_tick;
        logic sys_rst_n;
        logic cpu_rst_n;
        logic pin_oe_n;
        logic stop_mode;
        srsr_smr_fx_t fx;
    } srsr_ctl_t;

    srsr_ctl_t st_r;
    srsr_ctl_t st_nxt;

    logic pin_lvl;
    logic dly_load;
    logic [DLY_W-1:0] dly_val;
    logic dly_done;

    // delay in internal oscillator ticks for each reset cause
    function automatic logic [DLY_W-1:0] cause_delay(input srsr_cause_t c);
        logic [DLY_W-1:0] d;
        d = EXT_DLY_IPO;
        case (c)
            CAUSE_POR: d = POR_DLY_IPO;
            CAUSE_DBG: d = POR_DLY_IPO;
            CAUSE_BROWNOUT: d = BO_DLY_IPO;
            CAUSE_WDT: d = WDT_DLY_IPO;
            CAUSE_EXT: d = EXT_DLY_IPO;
            default: d = EXT_DLY_IPO;
        endcase
        return d;
    endfunction : cause_delay

    // flag that a reset cause raises
    function automatic srsr_flags_t cause_flag(input srsr_cause_t c);
        srsr_flags_t f;
        f = '0;
        case (c)
            CAUSE_POR: f.por = 1'b1;
            CAUSE_DBG: f.por = 1'b1;
            CAUSE_BROWNOUT: f.brownout = 1'b1;
            CAUSE_WDT: f.wdt = 1'b1;
            CAUSE_EXT: f.external_reset_flag = 1'b1;
            default: f = '0;
        endcase
        return f;
    endfunction : cause_flag

    // states in which the whole chip is held in reset
    function automatic logic held_state(input srsr_state_t s);
        return (s == ST_RESET) || (s == ST_WAIT_PIN);
    endfunction : held_state

    // the reset pin is asynchronous to the core clock
    srsr_pin_sync u_pin_sync (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .pin_i(RST_PIN_I),
        .level_o(pin_lvl)
    );

    // one delay counter serves every reset cause and the recovery
    srsr_delay #(
        .W(DLY_W)
    ) u_delay (
        .clk(CORE_CLK),
        .rst_n(RESET_N),
        .load(dly_load),
        .load_val(dly_val),
        .tick(st_r.ipo_tick),
        .done(dly_done)
    );

    logic in_reset;
    logic ext_active;
    logic ext_hit;
    logic int_req;
    srsr_cause_t cause;

    always_comb begin
        st_nxt = st_r;
        dly_load = 1'b0;
        dly_val = '0;
        st_nxt.fx = '0;
        // port mode is overridden for as long as the chip is held
        in_reset = held_state(st_r.state);

        // internal oscillator tick divider
        st_nxt.ipo_tick = 1'b0;
        if (st_r.div_cnt == DIV_W'(IPO_DIV - 1)) begin
            st_nxt.div_cnt = '0;
            st_nxt.ipo_tick = 1'b1;
        end else begin
            st_nxt.div_cnt = st_r.div_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
        end

        // pin acts as reset input unless in port mode outside reset
        ext_active = !PORT_MODE || in_reset;
        if (ext_active && !pin_lvl) begin
            // saturate so a long low level cannot wrap back to idle
            if (st_r.ext_cnt != EXT_CNT_W'(EXT_QUAL_CYC)) begin
                st_nxt.ext_cnt = st_r.ext_cnt + {{(EXT_CNT_W-1){1'b0}}, 1'b1};
            end
        end else begin
            st_nxt.ext_cnt = '0;
        end
        ext_hit = (st_r.ext_cnt == EXT_CNT_W'(EXT_QUAL_CYC));

        // debugger request bit, set wins over the self-clear
        if (st_r.state == ST_RESET) begin
            st_nxt.dbg_bit = 1'b0;
        end
        if (DBG_RST_SET) begin
            st_nxt.dbg_bit = 1'b1;
        end

        // cause priority
        int_req = RST_REQ.por || RST_REQ.brownout || RST_REQ.wdt_timeout || st_r.dbg_bit;
        if (RST_REQ.por) begin
            cause = CAUSE_POR;
        end else if (RST_REQ.brownout) begin
            cause = CAUSE_BROWNOUT;
        end else if (RST_REQ.wdt_timeout) begin
            cause = CAUSE_WDT;
        end else if (st_r.dbg_bit) begin
            cause = CAUSE_DBG;
        end else begin
            cause = CAUSE_EXT;
        end

        // flags: clear first so that a set in the same cycle wins
        if (FLAG_CLR) begin
            st_nxt.flags = '0;
        end

        case (st_r.state)
            ST_RUN: begin
                // a reset request outranks the stop instruction
                if (int_req || ext_hit) begin
                    st_nxt.state = ST_RESET;
                    dly_load = 1'b1;
                    dly_val = cause_delay(cause);
                    st_nxt.flags = st_nxt.flags | cause_flag(cause);
                end else if (STOP_EXEC) begin
                    st_nxt.state = ST_STOP;
                end
            end
            ST_STOP: begin
                if (int_req || ext_hit) begin
                    st_nxt.state = ST_RESET;
                    dly_load = 1'b1;
                    dly_val = cause_delay(cause);
                    st_nxt.flags = st_nxt.flags | cause_flag(cause);
                end else if (STOP_WAKE) begin
                    // wake restarts the oscillator, so only the cpu is held
                    st_nxt.state = ST_SMR;
                    dly_load = 1'b1;
                    // count starts at wake so oscillator start-up is inside it
                    dly_val = XTAL_EN ? SMR_XTAL_IPO : SMR_IPO_CYC;
                    st_nxt.fx.osc_defaults = 1'b1;
                    st_nxt.fx.wdt_ctl_update = 1'b1;
                    st_nxt.flags.stop = 1'b1;
                end
            end
            ST_SMR: begin
                // a request during recovery turns it into a full reset
                if (int_req || ext_hit) begin
                    st_nxt.state = ST_RESET;
                    dly_load = 1'b1;
                    dly_val = cause_delay(cause);
                    st_nxt.flags = st_nxt.flags | cause_flag(cause);
                end else if (dly_done) begin
                    st_nxt.state = ST_RUN;
                end
            end
            ST_RESET: begin
                // a held power or brownout request restarts the delay
                if (RST_REQ.por || RST_REQ.brownout) begin
                    dly_load = 1'b1;
                    dly_val = cause_delay(RST_REQ.por ? CAUSE_POR : CAUSE_BROWNOUT);
                end else if (dly_done) begin
                    st_nxt.state = ST_WAIT_PIN;
                end
            end
            ST_WAIT_PIN: begin
                // the board may still hold the pin low after the delay
                if (RST_REQ.por || RST_REQ.brownout || RST_REQ.wdt_timeout) begin
                    st_nxt.state = ST_RESET;
                    dly_load = 1'b1;
                    dly_val = cause_delay(cause);
                    st_nxt.flags = st_nxt.flags | cause_flag(cause);
                end else if (pin_lvl) begin
                    st_nxt.state = ST_RUN;
                end else begin
                    st_nxt.state = ST_WAIT_PIN;
                end
            end
            default: begin
                st_nxt.state = ST_RESET;
                dly_load = 1'b1;
                dly_val = cause_delay(CAUSE_POR);
            end
        endcase

        // registered outputs follow the next state
        st_nxt.sys_rst_n = !held_state(st_nxt.state);
        st_nxt.cpu_rst_n = st_nxt.sys_rst_n && (st_nxt.state != ST_SMR);
        st_nxt.stop_mode = (st_nxt.state == ST_STOP);
        if (st_nxt.state == ST_RESET) begin
            st_nxt.pin_oe_n = 1'b0;
        end else if (st_nxt.sys_rst_n && PORT_MODE) begin
            st_nxt.pin_oe_n = !PORT_DRIVE_LOW;
        end else begin
            st_nxt.pin_oe_n = 1'b1;
        end
    end

    // reset values: chip held, pin driven low, only the power-on flag set
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_r.state <= ST_RESET;
            st_r.flags <= FLAGS_RST;
            st_r.dbg_bit <= 1'b0;
            st_r.ext_cnt <= '0;
            st_r.div_cnt <= '0;
            st_r.ipo_tick <= 1'b0;
            st_r.sys_rst_n <= 1'b0;
            st_r.cpu_rst_n <= 1'b0;
            st_r.pin_oe_n <= 1'b0;
            st_r.stop_mode <= 1'b0;
            st_r.fx <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // open-drain: only ever drives low
    assign RST_PIN_O = 1'b0;
    assign RST_PIN_OE_N = st_r.pin_oe_n;
    assign PORT_PIN_LEVEL = pin_lvl;
    assign SYS_RST_N = st_r.sys_rst_n;
    assign CPU_RST_N = st_r.cpu_rst_n;
    assign STOP_MODE = st_r.stop_mode;
    assign DBG_RST_BIT = st_r.dbg_bit;
    assign RST_FLAGS = st_r.flags;
    assign SMR_FX = st_r.fx;

endmodule : srsr_top

// File: verification/srsr_board.sv
// Purpose: board reset net seen by the reset pin
// Assumes: pull-up on the net, idle high
// Notes: ext_low models a switch or other board part pulling low
`timescale 1ns/1ps
module srsr_board (
    input wire logic oe_n,
    input wire logic o,
    input wire logic ext_low,
    output logic pin
);
    // wired-and, pull-up when nobody drives
    assign pin = ((!oe_n && !o) || ext_low) ? 1'b0 : 1'b1;
endmodule : srsr_board

// File: verification/srsr_top_sva.sv
// Purpose: port checks of the reset controller
// Assumes: single clock domain
// Notes: bound into srsr_top
`timescale 1ns/1ps
module srsr_top_sva #(
    parameter int IPO_DIV = 45,
    parameter logic [15:0] SMR_XTAL_IPO = 16'h1388
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic RST_PIN_I,
    input wire logic RST_PIN_O,
    input wire logic RST_PIN_OE_N,
    input wire srsr_pkg::srsr_req_t RST_REQ,
    input wire logic DBG_RST_SET,
    input wire logic STOP_EXEC,
    input wire logic STOP_WAKE,
    input wire logic XTAL_EN,
    input wire logic PORT_MODE,
    input wire logic PORT_PIN_LEVEL,
    input wire logic SYS_RST_N,
    input wire logic CPU_RST_N,
    input wire logic STOP_MODE,
    input wire logic DBG_RST_BIT,
    input wire srsr_pkg::srsr_flags_t RST_FLAGS,
    input wire srsr_pkg::srsr_smr_fx_t SMR_FX
);
    import srsr_pkg::*;
    logic [15:0] hold_r;
    int d_ipo;
    assign d_ipo = XTAL_EN ? int'(SMR_XTAL_IPO) : int'(SMR_IPO_CYC);
    // length of the cpu-only hold
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            hold_r <= 16'h0;
        end else begin
            hold_r <= (!CPU_RST_N && SYS_RST_N) ? hold_r + 16'h1 : 16'h0;
        end
    end
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    sequence s_wake;
        STOP_MODE && STOP_WAKE;
    endsequence
    sequence s_smr_go;
        !CPU_RST_N && !STOP_MODE && SMR_FX == 2'b11 && RST_FLAGS.stop;
    endsequence
    AST_OPEN_DRAIN: assert property (RST_PIN_O == 1'b0 &&
        (!$fell(SYS_RST_N) || !RST_PIN_OE_N)) else $error("pin not driven low at reset");
    AST_WDT_REQ: assert property (SYS_RST_N && RST_REQ.wdt_timeout |=>
        !SYS_RST_N && !RST_PIN_OE_N && RST_FLAGS.wdt) else $error("watchdog not taken");
    AST_POWER_REQ: assert property (SYS_RST_N && (RST_REQ.por || RST_REQ.brownout) |=>
        !SYS_RST_N && !CPU_RST_N) else $error("power request not taken");
    AST_DBG_REQ: assert property (SYS_RST_N && DBG_RST_SET |=>
        DBG_RST_BIT ##1 !SYS_RST_N ##1 !DBG_RST_BIT) else $error("debugger request wrong");
    AST_STOP_IN: assert property (SYS_RST_N && CPU_RST_N && !STOP_MODE && STOP_EXEC
        |=> STOP_MODE) else $error("stop not entered");
    AST_SMR_GO: assert property (s_wake |=> s_smr_go ##1 SMR_FX == 2'b00)
        else $error("recovery start wrong");
    AST_SMR_SYS: assert property (s_wake |=> SYS_RST_N [*8])
        else $error("recovery reset the system");
    AST_SMR_LEN: assert property ($rose(CPU_RST_N) && hold_r != 16'h0 |->
        hold_r >= (d_ipo - 1) * IPO_DIV && hold_r <= (d_ipo + 1) * IPO_DIV + 3)
        else $error("recovery length wrong");
    AST_PIN_HOLD: assert property (!PORT_PIN_LEVEL && !SYS_RST_N |=> !SYS_RST_N)
        else $error("left reset with pin low");
    AST_RELEASE: assert property ($rose(SYS_RST_N) |-> $past(PORT_PIN_LEVEL) && RST_PIN_OE_N)
        else $error("release without pin high");
    AST_EXT_LOW: assert property ((!RST_PIN_I && !PORT_MODE) [*8] |=> !SYS_RST_N)
        else $error("held pin not taken");
endmodule : srsr_top_sva
bind srsr_top srsr_top_sva #(.IPO_DIV(IPO_DIV), .SMR_XTAL_IPO(SMR_XTAL_IPO)) u_srsr_top_sva (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .RST_PIN_I(RST_PIN_I), .RST_PIN_O(RST_PIN_O),
    .RST_PIN_OE_N(RST_PIN_OE_N), .RST_REQ(RST_REQ), .DBG_RST_SET(DBG_RST_SET),
    .STOP_EXEC(STOP_EXEC), .STOP_WAKE(STOP_WAKE), .XTAL_EN(XTAL_EN), .PORT_MODE(PORT_MODE),
    .PORT_PIN_LEVEL(PORT_PIN_LEVEL), .SYS_RST_N(SYS_RST_N), .CPU_RST_N(CPU_RST_N),
    .STOP_MODE(STOP_MODE), .DBG_RST_BIT(DBG_RST_BIT), .RST_FLAGS(RST_FLAGS), .SMR_FX(SMR_FX));

// File: verification/srsr_top_tb.sv
// Purpose: directed bench of the reset controller
// Assumes: short delays, 2 clocks per oscillator tick
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module srsr_top_tb;
    import srsr_pkg::*;
    localparam int DIV = 2;
    logic clk;
    logic rst_n;
    logic pin;
    logic pin_o;
    logic oe_n;
    logic ext_low;
    srsr_req_t req;
    logic dbg_set;
    logic stop_exec;
    logic stop_wake;
    logic xtal_en;
    logic port_mode;
    logic port_low;
    logic flag_clr;
    logic pin_lvl;
    logic sys_n;
    logic cpu_n;
    logic stop_m;
    logic dbg_bit;
    srsr_flags_t flags;
    srsr_smr_fx_t fx;
    int error_cnt;
    int tests_run;
    srsr_top #(.IPO_DIV(DIV), .POR_DLY_IPO(16'h0008), .BO_DLY_IPO(16'h0008),
        .WDT_DLY_IPO(16'h0004), .EXT_DLY_IPO(16'h0004), .SMR_XTAL_IPO(16'h0014)) u_srsr_top (
        .CORE_CLK(clk), .RESET_N(rst_n), .RST_PIN_I(pin), .RST_PIN_O(pin_o),
        .RST_PIN_OE_N(oe_n), .RST_REQ(req), .DBG_RST_SET(dbg_set), .STOP_EXEC(stop_exec),
        .STOP_WAKE(stop_wake), .XTAL_EN(xtal_en), .PORT_MODE(port_mode),
        .PORT_DRIVE_LOW(port_low), .FLAG_CLR(flag_clr), .PORT_PIN_LEVEL(pin_lvl),
        .SYS_RST_N(sys_n), .CPU_RST_N(cpu_n), .STOP_MODE(stop_m), .DBG_RST_BIT(dbg_bit),
        .RST_FLAGS(flags), .SMR_FX(fx));
    srsr_board u_srsr_board (.oe_n(oe_n), .o(pin_o), .ext_low(ext_low), .pin(pin));
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // waits for sys (0), pin enable (1) or cpu (2) reset to reach val
    task automatic wait_for(input int sel, input logic val, input int lim, output int n);
        n = 0;
        while (((sel == 0) ? sys_n : (sel == 1) ? oe_n : cpu_n) !== val) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                error_cnt++;
                $display("unexpected at %0t: wait %h for %h", $time, sel, val);
                complete_run();
            end
        end
    endtask : wait_for
    function automatic logic in_win(input int n, input int d);
        return n >= d * DIV - DIV - 2 && n <= d * DIV + DIV + 2;
    endfunction : in_win
    task automatic clr;
        flag_clr = 1'b1;
        @(negedge clk);
        flag_clr = 1'b0;
    endtask : clr
    task automatic t_pulse(input int len, input logic hit);
        int n;
        clr();
        ext_low = 1'b1;
        repeat (len) @(negedge clk);
        ext_low = 1'b0;
        n = 0;
        repeat (12) begin
            @(negedge clk);
            if (sys_n === 1'b0) n++;
        end
        chk(n != 0, hit);
        chk(flags.external_reset_flag, hit);
        wait_for(0, 1'b1, 40, n);
        $display("test pulse %0d done", len);
    endtask : t_pulse
    task automatic t_hold;
        int n;
        int hi;
        hi = 0;
        ext_low = 1'b1;
        repeat (10) @(negedge clk);
        repeat (60) begin
            @(negedge clk);
            if (sys_n !== 1'b0) hi++;
        end
        chk(hi == 0, 1'b1);
        ext_low = 1'b0;
        wait_for(0, 1'b1, 8, n);
        chk(cpu_n, 1'b1);
        $display("test hold done");
    endtask : t_hold
    task automatic t_req(input int k, input logic [7:0] fl, input int d);
        int n;
        clr();
        case (k)
            0: req.por = 1'b1;
            1: req.brownout = 1'b1;
            2: req.wdt_timeout = 1'b1;
            default: dbg_set = 1'b1;
        endcase
        @(negedge clk);
        req = '0;
        dbg_set = 1'b0;
        if (k == 3) begin
            // the written bit raises the reset one cycle later
            chk(dbg_bit, 1'b1);
            @(negedge clk);
        end
        chk({sys_n, oe_n}, 2'b00);
        @(negedge clk);
        chk(dbg_bit, 1'b0);
        wait_for(1, 1'b1, 400, n);
        chk(in_win(n, d), 1'b1);
        wait_for(0, 1'b1, 10, n);
        chk(flags, fl);
        $display("test request %0d done", k);
    endtask : t_req
    task automatic t_stop(input logic xt);
        int n;
        clr();
        xtal_en = xt;
        stop_exec = 1'b1;
        @(negedge clk);
        stop_exec = 1'b0;
        chk(stop_m, 1'b1);
        repeat (5) @(negedge clk);
        stop_wake = 1'b1;
        @(negedge clk);
        stop_wake = 1'b0;
        chk({stop_m, cpu_n, fx}, 4'b0011);
        @(negedge clk);
        chk(fx, 2'b00);
        wait_for(2, 1'b1, 400, n);
        chk(in_win(n + 1, xt ? 20 : 66), 1'b1);
        chk({sys_n, flags}, 6'h21);
        $display("test stop %h done", xt);
    endtask : t_stop
    task automatic t_port;
        int n;
        port_mode = 1'b1;
        port_low = 1'b1;
        repeat (6) @(negedge clk);
        chk({oe_n, pin_lvl, sys_n}, 3'b001);
        port_low = 1'b0;
        ext_low = 1'b1;
        repeat (12) @(negedge clk);
        chk({pin_lvl, sys_n}, 2'b01);
        req.wdt_timeout = 1'b1;
        @(negedge clk);
        req = '0;
        repeat (40) @(negedge clk);
        chk(sys_n, 1'b0);
        ext_low = 1'b0;
        wait_for(0, 1'b1, 10, n);
        port_mode = 1'b0;
        $display("test port done");
    endtask : t_port
    task automatic t_rst;
        int n;
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        chk({sys_n, cpu_n, oe_n, flags}, 8'h10);
        rst_n = 1'b1;
        wait_for(0, 1'b1, 20, n);
        chk(cpu_n, 1'b1);
        $display("test reset done");
    endtask : t_rst
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        int n;
        error_cnt = 0;
        tests_run = 0;
        rst_n = 1'b0;
        ext_low = 1'b0;
        req = '0;
        dbg_set = 1'b0;
        stop_exec = 1'b0;
        stop_wake = 1'b0;
        xtal_en = 1'b0;
        port_mode = 1'b0;
        port_low = 1'b0;
        flag_clr = 1'b0;
        repeat (12) @(negedge clk);
        chk(flags, 8'h10);
        rst_n = 1'b1;
        wait_for(0, 1'b1, 20, n);
        t_pulse(2, 1'b0);
        t_pulse(4, 1'b1);
        t_hold();
        t_req(0, 8'h10, 8);
        t_req(1, 8'h08, 8);
        t_req(2, 8'h04, 4);
        t_req(3, 8'h10, 8);
        t_stop(1'b0);
        t_stop(1'b1);
        t_port();
        t_rst();
        complete_run();
    end
endmodule : srsr_top_tb
